// ===== logic/tsw_regs.vh
/*
 * Register map, field positions, reset values and timing counts of the
 * time-slot switch core.
 * Assumes a 32-bit APB with an 18-bit byte address.
 */
`ifndef TSW_REGS_VH
`define TSW_REGS_VH

// ----------------------------------------------------------------
// Byte addresses
// ----------------------------------------------------------------
`define TSW_ADDR_CTRL 18'h00000
`define TSW_ADDR_ALIGN 18'h00004
`define TSW_ADDR_OFS_BASE 18'h00080
`define TSW_OFS_MASK 18'h3ff80
`define TSW_PAGE_REG 2'h0
`define TSW_PAGE_CM 2'h1
`define TSW_PAGE_DM 2'h2

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define TSW_CTRL_RESET 16'h0000
`define TSW_CTRL_EVAL 4
`define TSW_CTRL_STBY 5
`define TSW_CTRL_GO 6
`define TSW_CTRL_BPD_HI 9
`define TSW_CTRL_BPD_LO 7
`define TSW_CTRL_SPLIT 10
`define TSW_CTRL_MBP 11

// ----------------------------------------------------------------
// Connection store word fields, channel modes and the 16M rate code
// ----------------------------------------------------------------
`define TSW_CM_MODE_HI 15
`define TSW_CM_MODE_LO 14
`define TSW_CM_LOOP 13
`define TSW_MODE_VAR 2'h0
`define TSW_MODE_CONST 2'h1
`define TSW_MODE_PROC 2'h2
`define TSW_MODE_HIZ 2'h3
`define TSW_RATE_16M 2'h3

// ----------------------------------------------------------------
// Timing counts
// ----------------------------------------------------------------
`define TSW_FMT_RUN 4'h8
`define TSW_EVAL_LOW_FRAMES 2'h2
`define TSW_BP_LAST 11'h7ff

`endif

// ===== logic/tsw_rx_lane.v
/*
 * Serial-to-parallel lane for one input stream.
 * Assumes cyc counts master clocks from the frame start and that rate is
 * never faster than fast.
 */
`timescale 1ns/1ps
`include "tsw_regs.vh"

module tsw_rx_lane (
    input wire pclk, // Master clock
    input wire presetn, // Async reset, active low
    input wire [11:0] cyc, // Clocks since frame start
    input wire [1:0] rate, // Stream rate code
    input wire [1:0] fast, // Fastest rate code
    input wire [3:0] offset, // Offset in half clocks
    input wire rx_bit, // Serial input bit
    output reg wr_r, // Byte complete pulse
    output reg [7:0] ch_r, // Channel of byte
    output reg [7:0] byte_r // Received byte
);

    wire [2:0] sh = {1'b0, fast} - {1'b0, rate} + {2'b00, fast != `TSW_RATE_16M};
    wire [11:0] ofs = {9'h000, offset[3:1]};
    wire [11:0] c = cyc - ofs;
    wire [11:0] bidx = c >> sh;
    wire [11:0] mask = ~(12'hfff << sh);
    wire [11:0] samp = (12'h003 << sh) >> 2;
    wire hit = (cyc >= ofs) && ((c & mask) == samp);
    wire last = hit && (bidx[2:0] == 3'h7);
    reg [6:0] sr_r;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sr_r <= 7'h00;
            wr_r <= 1'b0;
            ch_r <= 8'h00;
            byte_r <= 8'h00;
        end else begin
            wr_r <= last;
            if (hit) begin
                sr_r <= {sr_r[5:0], rx_bit};
            end
            if (last) begin
                byte_r <= {sr_r, rx_bit};
                ch_r <= bidx[10:3];
            end
        end
    end

endmodule // tsw_rx_lane

// ===== logic/tsw_tx_lane.v
/*
 * Parallel-to-serial lane for one output stream.
 * Assumes cw and db answer combinationally for the channel on ch.
 */
`timescale 1ns/1ps
`include "tsw_regs.vh"

module tsw_tx_lane (
    input wire pclk, // Master clock
    input wire presetn, // Async reset, active low
    input wire [11:0] cyc, // Clocks since frame start
    input wire [1:0] rate, // Stream rate code
    input wire [1:0] fast, // Fastest rate code
    input wire en_all, // Drive pin or standby bit
    input wire [15:0] cw, // Connection word of ch
    input wire [7:0] db, // Data store byte of source
    output wire [7:0] ch, // Channel now starting
    output reg tx_bit_r, // Serial output bit
    output reg tx_oe_r, // Output enable
    output reg loop_r // Loopback of current channel
);

    wire [2:0] sh = {1'b0, fast} - {1'b0, rate} + {2'b00, fast != `TSW_RATE_16M};
    wire [11:0] bidx = cyc >> sh;
    wire [11:0] mask = ~(12'hfff << sh);
    wire launch = (cyc & mask) == 12'h000;
    wire [1:0] mode = cw[`TSW_CM_MODE_HI:`TSW_CM_MODE_LO];
    wire [7:0] pick = (mode == `TSW_MODE_PROC) ? cw[7:0] : db;
    reg [7:0] cur_r;
    reg hiz_r;

    assign ch = bidx[10:3];

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cur_r <= 8'h00;
            hiz_r <= 1'b1;
            tx_bit_r <= 1'b0;
            tx_oe_r <= 1'b0;
            loop_r <= 1'b0;
        end else begin
            tx_oe_r <= en_all && !hiz_r;
            if (launch && bidx[2:0] == 3'h0) begin
                cur_r <= pick;
                tx_bit_r <= pick[7];
                hiz_r <= (mode == `TSW_MODE_HIZ);
                tx_oe_r <= en_all && (mode != `TSW_MODE_HIZ);
                loop_r <= cw[`TSW_CM_LOOP];
            end else if (launch) begin
                tx_bit_r <= cur_r[~bidx[2:0]];
            end
        end
    end

endmodule // tsw_tx_lane

// ===== logic/tsw_core.v
/*
 * Time-slot interchange core: 32 input and 32 output serial streams,
 * data store with frame banks, connection store, APB register slave,
 * frame format detection, alignment measurement and block programming.
 * Assumes pclk is the master serial clock and that the serial pins and
 * frame pulses are asynchronous to it.
 */
`timescale 1ns/1ps
`include "tsw_regs.vh"

module tsw_core (
    input wire pclk, // Master clock
    input wire presetn, // Async reset, active low
    input wire psel, // APB select
    input wire penable, // APB enable
    input wire pwrite, // APB direction
    input wire [17:0] paddr, // APB byte address
    input wire [31:0] pwdata, // APB write data
    output reg [31:0] prdata, // APB read data
    output wire pready, // APB ready
    output wire pslverr, // APB error
    input wire frame_sync_in, // Frame pulse
    input wire frame_measure_in, // Frame measurement input
    input wire drive_enable_pin, // Output drive enable
    input wire [31:0] rx_in, // Serial inputs
    output wire [31:0] tx_out, // Serial outputs
    output wire [31:0] tx_oe // Output enables
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    localparam EV_IDLE = 2'h0;
    localparam EV_WAIT = 2'h1;
    localparam EV_MEAS = 2'h2;

    reg [34:0] sync1_r;
    reg [34:0] sync2_r;
    reg fs3_r;
    reg fe3_r;
    reg [3:0] run_r;
    reg fmt_r;
    reg [11:0] cyc_r;
    reg [1:0] fb_r;
    reg [15:0] ctrl_r;
    reg [3:0] ofs_r [0:31];
    reg [10:0] bp_addr_r;
    reg [1:0] ev_st_r;
    reg eval_d_r;
    reg [1:0] low_cnt_r;
    reg [11:0] fe_cnt_r;
    reg [11:0] result_r;
    reg got_r;
    reg done_r;
    reg [15:0] cm [0:8191];
    reg [7:0] dm_last [0:8191];
    reg [7:0] dm_bank [0:32767];

    wire [31:0] rx_s = sync2_r[31:0];
    wire fs2 = sync2_r[32];
    wire fe2 = sync2_r[33];
    wire de2 = sync2_r[34];
    wire [31:0] rx_wr;
    wire [255:0] rx_ch;
    wire [255:0] rx_byte;
    wire [31:0] tx_loop;

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_r <= 35'h0;
            sync2_r <= 35'h0;
            fs3_r <= 1'b0;
            fe3_r <= 1'b0;
        end else begin
            sync1_r <= {drive_enable_pin, frame_measure_in, frame_sync_in, rx_in};
            sync2_r <= sync1_r;
            fs3_r <= fs2;
            fe3_r <= fe2;
        end
    end

    // ----------------------------------------------------------------
    // Frame format detection and frame counter
    // ----------------------------------------------------------------
    // Idle level of the pulse decides the format: idle high is the
    // falling-edge format (fmt 0), idle low is GCI (fmt 1).
    wire frame_start = (fs2 != fs3_r) && (fs2 == fmt_r);
    wire fe_edge = (fe2 != fe3_r) && (fe2 == fmt_r);

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_r <= 4'h0;
            fmt_r <= 1'b0;
            cyc_r <= 12'h000;
            fb_r <= 2'h0;
        end else begin
            if (fs2 != fs3_r) begin
                run_r <= 4'h0;
            end else if (run_r != `TSW_FMT_RUN) begin
                run_r <= run_r + 4'h1;
            end else begin
                fmt_r <= !fs2;
            end
            if (frame_start) begin
                cyc_r <= 12'h000;
                fb_r <= (fb_r == 2'h2) ? 2'h0 : fb_r + 2'h1;
            end else if (cyc_r != 12'hfff) begin
                cyc_r <= cyc_r + 12'h001;
            end
        end
    end

    // ----------------------------------------------------------------
    // Rate configuration
    // ----------------------------------------------------------------
    wire [1:0] dr_lo = ctrl_r[1:0];
    wire [1:0] dr_hi = ctrl_r[3:2];
    wire regular = (dr_hi == 2'h0);
    wire split = ctrl_r[`TSW_CTRL_SPLIT];
    wire [1:0] other = regular ? dr_lo : dr_hi - 2'h1;
    wire [1:0] fast = (other > dr_lo) ? other : dr_lo;
    wire en_all = de2 | ctrl_r[`TSW_CTRL_STBY];
    wire [1:0] bank_rd = (fb_r == 2'h2) ? 2'h0 : fb_r + 2'h1;

    // ----------------------------------------------------------------
    // Stream lanes
    // ----------------------------------------------------------------
    genvar s;
    generate
        for (s = 0; s < 32; s = s + 1) begin : g_lane
            wire hi_half = (s >= 16);
            wire [1:0] rx_rate = (!regular && split && hi_half) ? other : dr_lo;
            wire [1:0] tx_rate = regular ? dr_lo : (split ? rx_rate : other);
            wire [7:0] tch;
            wire [31:0] s_idx = s;
            wire [4:0] sn = s_idx[4:0];
            wire [15:0] cw = cm[{sn, tch}];
            wire [12:0] src = cw[12:0];
            wire is_const = cw[`TSW_CM_MODE_HI:`TSW_CM_MODE_LO] == `TSW_MODE_CONST;
            wire [7:0] db = is_const ? dm_bank[{bank_rd, src}] : dm_last[src];
            wire rx_bit = tx_loop[s] ? tx_out[s] : rx_s[s];

            tsw_rx_lane u_rx (
                .pclk(pclk),
                .presetn(presetn),
                .cyc(cyc_r),
                .rate(rx_rate),
                .fast(fast),
                .offset(ofs_r[s]),
                .rx_bit(rx_bit),
                .wr_r(rx_wr[s]),
                .ch_r(rx_ch[s*8 +: 8]),
                .byte_r(rx_byte[s*8 +: 8])
            );

            tsw_tx_lane u_tx (
                .pclk(pclk),
                .presetn(presetn),
                .cyc(cyc_r),
                .rate(tx_rate),
                .fast(fast),
                .en_all(en_all),
                .cw(cw),
                .db(db),
                .ch(tch),
                .tx_bit_r(tx_out[s]),
                .tx_oe_r(tx_oe[s]),
                .loop_r(tx_loop[s])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // Data store: written only by the input lanes
    // ----------------------------------------------------------------
    always @(posedge pclk) begin : dm_write
        integer i;
        for (i = 0; i < 32; i = i + 1) begin
            if (rx_wr[i]) begin
                dm_last[{i[4:0], rx_ch[i*8 +: 8]}] <= rx_byte[i*8 +: 8];
                dm_bank[{fb_r, i[4:0], rx_ch[i*8 +: 8]}] <= rx_byte[i*8 +: 8];
            end
        end
    end

    // ----------------------------------------------------------------
    // APB decode
    // ----------------------------------------------------------------
    wire setup = psel && !penable;
    wire wr_en = psel && penable && pwrite;
    wire [1:0] page = paddr[17:16];
    wire [12:0] midx = paddr[14:2];
    wire sel_ctrl = (paddr == `TSW_ADDR_CTRL);
    wire sel_align = (paddr == `TSW_ADDR_ALIGN);
    wire sel_ofs = ((paddr & `TSW_OFS_MASK) == `TSW_ADDR_OFS_BASE) && (paddr[1:0] == 2'h0);
    wire sel_cm = (page == `TSW_PAGE_CM) && !paddr[15] && (paddr[1:0] == 2'h0);
    wire sel_dm = (page == `TSW_PAGE_DM) && !paddr[15] && (paddr[1:0] == 2'h0);
    wire mapped = sel_ctrl | sel_align | sel_ofs | sel_cm | sel_dm;
    wire bp_run = ctrl_r[`TSW_CTRL_GO] && ctrl_r[`TSW_CTRL_MBP];
    wire bp_last = bp_run && (bp_addr_r == `TSW_BP_LAST);

    assign pready = 1'b1;
    assign pslverr = psel && penable && (!mapped || (pwrite && (sel_align || sel_dm)));

    // Read data is latched in the setup cycle so prdata comes from a flop
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (setup) begin
            if (sel_ctrl) begin
                prdata <= {16'h0000, ctrl_r};
            end else if (sel_align) begin
                prdata <= {18'h00000, fmt_r, done_r, result_r};
            end else if (sel_ofs) begin
                prdata <= {28'h0000000, ofs_r[paddr[6:2]]};
            end else if (sel_cm) begin
                prdata <= {16'h0000, cm[midx]};
            end else if (sel_dm) begin
                prdata <= {24'h000000, dm_last[midx]};
            end else begin
                prdata <= 32'h00000000;
            end
        end
    end

    // ----------------------------------------------------------------
    // Control and offset registers
    // ----------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= `TSW_CTRL_RESET;
        end else if (wr_en && sel_ctrl) begin
            ctrl_r <= pwdata[15:0];
        end else if (bp_last) begin
            ctrl_r[`TSW_CTRL_GO] <= 1'b0;
        end
    end

    always @(posedge pclk or negedge presetn) begin : ofs_regs
        integer j;
        if (!presetn) begin
            for (j = 0; j < 32; j = j + 1) begin
                ofs_r[j] <= 4'h0;
            end
        end else if (wr_en && sel_ofs) begin
            ofs_r[paddr[6:2]] <= pwdata[3:0];
        end
    end

    // ----------------------------------------------------------------
    // Connection store and block programming
    // ----------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bp_addr_r <= 11'h000;
        end else if (bp_run) begin
            bp_addr_r <= bp_addr_r + 11'h001;
        end else begin
            bp_addr_r <= 11'h000;
        end
    end

    // Four words per clock covers the whole store in 2048 clocks
    always @(posedge pclk) begin : cm_write
        integer k;
        if (bp_run) begin
            for (k = 0; k < 4; k = k + 1) begin
                cm[{bp_addr_r, k[1:0]}] <=
                    {ctrl_r[`TSW_CTRL_BPD_HI:`TSW_CTRL_BPD_LO], 13'h0000};
            end
        end else if (wr_en && sel_cm) begin
            cm[midx] <= pwdata[15:0];
        end
    end

    // ----------------------------------------------------------------
    // Frame alignment measurement
    // ----------------------------------------------------------------
    wire eval_bit = ctrl_r[`TSW_CTRL_EVAL];
    wire eval_go = eval_bit && !eval_d_r && (low_cnt_r == `TSW_EVAL_LOW_FRAMES);
    wire done_set = (ev_st_r == EV_MEAS) && frame_start && eval_bit;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ev_st_r <= EV_IDLE;
            eval_d_r <= 1'b0;
            low_cnt_r <= 2'h0;
            fe_cnt_r <= 12'h000;
            result_r <= 12'h000;
            got_r <= 1'b0;
            done_r <= 1'b0;
        end else begin
            eval_d_r <= eval_bit;
            if (eval_bit) begin
                low_cnt_r <= 2'h0;
            end else if (frame_start && low_cnt_r != `TSW_EVAL_LOW_FRAMES) begin
                low_cnt_r <= low_cnt_r + 2'h1;
            end
            if (done_set) begin
                done_r <= 1'b1;
            end else if (!eval_bit) begin
                done_r <= 1'b0;
            end
            if (frame_start) begin
                fe_cnt_r <= 12'h000;
            end else if (fe_cnt_r != 12'hfff) begin
                fe_cnt_r <= fe_cnt_r + 12'h001;
            end
            case (ev_st_r)
                EV_IDLE: begin
                    if (eval_go) begin
                        ev_st_r <= EV_WAIT;
                    end
                end
                EV_WAIT: begin
                    if (!eval_bit) begin
                        ev_st_r <= EV_IDLE;
                    end else if (frame_start) begin
                        got_r <= 1'b0;
                        ev_st_r <= EV_MEAS;
                    end
                end
                EV_MEAS: begin
                    if (fe_edge && !got_r) begin
                        result_r <= fe_cnt_r;
                        got_r <= 1'b1;
                    end
                    if (!eval_bit || frame_start) begin
                        ev_st_r <= EV_IDLE;
                    end
                end
                default: begin
                    ev_st_r <= EV_IDLE;
                end
            endcase
        end
    end

endmodule // tsw_core

// ===== verification/tsw_core_properties.sv
/* Port checker for tsw_core.
   Assumes binding to tsw_core, APB zero-wait slave. */
`timescale 1ns/1ps
module tsw_core_checker (
    input wire pclk, // Clock
    input wire presetn, // Reset, active low
    input wire psel, // APB select
    input wire penable, // APB enable
    input wire pwrite, // APB direction
    input wire [17:0] paddr, // APB address
    input wire [31:0] pwdata, // APB write data
    input wire [31:0] prdata, // APB read data
    input wire pready, // APB ready
    input wire pslverr, // APB error
    input wire drive_enable_pin, // Drive enable
    input wire [31:0] tx_oe // Output enables
);
default clocking @(posedge pclk); endclocking
default disable iff (!presetn);
wire acc = psel && penable;
reg stby_r;
reg [2:0] quiet_r;
// ----------------------------------------
// Shadow of standby bit and quiet count
// ----------------------------------------
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        stby_r <= 1'b0;
        quiet_r <= 3'h0;
    end else begin
        if (acc && pwrite && paddr == 18'h00000)
            stby_r <= pwdata[5];
        if (drive_enable_pin || stby_r)
            quiet_r <= 3'h0;
        else if (quiet_r != 3'h7)
            quiet_r <= quiet_r + 3'h1;
    end
end
a_ready_high: assert property (acc |-> pready) else $error("pready low");
a_unmapped_err: assert property (acc && paddr[17:16] == 2'h3 |-> pslverr && prdata == 32'h0)
    else $error("unmapped access");
a_align_ro: assert property (acc && pwrite && paddr == 18'h00004 |-> pslverr)
    else $error("align write");
a_dstore_ro: assert property (acc && pwrite && paddr[17:16] == 2'h2 |-> pslverr)
    else $error("data store write");
a_ctrl_ok: assert property (acc && paddr == 18'h00000 |-> !pslverr) else $error("ctrl err");
a_all_hiz: assert property (quiet_r >= 3'h5 |-> tx_oe == 32'h0)
    else $error("outputs driven");
a_prdata_hold: assert property (!(psel && !penable) |=> $stable(prdata))
    else $error("prdata moved");
a_reset_quiet: assert property ($rose(presetn) |-> tx_oe == 32'h0 && prdata == 32'h0)
    else $error("reset state");
a_err_access: assert property (pslverr |-> acc) else $error("stray error");
c_err: cover property (acc && pslverr);
c_go: cover property (acc && pwrite && paddr == 18'h00000 && pwdata[6]);
c_drive: cover property (tx_oe != 32'h0);
endmodule // tsw_core_checker
bind tsw_core tsw_core_checker tsw_core_checker_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .drive_enable_pin(drive_enable_pin), .tx_oe(tx_oe));

// ===== verification/tsw_far_end.sv
/* Far-end framer: frame pulse, measure input and 32 serial streams.
   Assumes two clocks per bit, falling-edge framing. */
`timescale 1ns/1ps
module tsw_far_end #(parameter FRAME = 2048, parameter MEAS_DLY = 37) (
    input wire pclk, // Clock
    input wire presetn, // Reset, active low
    output reg frame_sync_in, // Frame pulse, active low
    output reg frame_measure_in, // Measure input
    output reg [31:0] rx_in // Serial streams
);
reg [11:0] cnt_r;
reg [7:0] b_v;
integer s;
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        cnt_r <= 12'h000;
        frame_sync_in <= 1'b1;
        frame_measure_in <= 1'b1;
        rx_in <= 32'h00000000;
    end else begin
        cnt_r <= (cnt_r == FRAME - 1) ? 12'h000 : cnt_r + 12'h001;
        // Pulse leads the first bit of the frame by one clock
        frame_sync_in <= (cnt_r != FRAME - 1);
        frame_measure_in <= (cnt_r != MEAS_DLY);
        for (s = 0; s < 32; s = s + 1) begin
            b_v = {s[2:0], cnt_r[8:4]};
            rx_in[s] <= b_v[~cnt_r[3:1]];
        end
    end
end
endmodule // tsw_far_end

// ===== verification/tdm_timeslot_switch_core_bench.sv
/* Self-checking bench for tsw_core.
   Assumes tsw_far_end on the serial side. */
`timescale 1ns/1ps
`include "tsw_regs.vh"
module tdm_timeslot_switch_core_bench;
localparam FRAME = 2048;
localparam MEAS = 37;
reg pclk, presetn, psel, penable, pwrite, drive_enable_pin;
reg [17:0] paddr;
reg [31:0] pwdata, rd;
reg er;
wire [31:0] prdata, rx_in, tx_out, tx_oe;
wire pready, pslverr, frame_sync_in, frame_measure_in;
integer miscompares = 0;
integer cmp_count = 0;
integer cyc_n = 0;
tsw_core tsw_core_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .frame_sync_in(frame_sync_in), .frame_measure_in(frame_measure_in),
    .drive_enable_pin(drive_enable_pin), .rx_in(rx_in), .tx_out(tx_out), .tx_oe(tx_oe));
tsw_far_end #(.FRAME(FRAME), .MEAS_DLY(MEAS)) tsw_far_end_inst (.pclk(pclk),
    .presetn(presetn), .frame_sync_in(frame_sync_in), .frame_measure_in(frame_measure_in),
    .rx_in(rx_in));
initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
end
function [7:0] pat(input [4:0] st, input [7:0] ch);
    pat = {st[2:0], ch[4:0]};
endfunction
function [17:0] ad(input [17:0] base, input [4:0] st, input [7:0] ch);
    ad = base + {3'h0, st, ch, 2'h0};
endfunction
task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    cmp_count = cmp_count + 1;
    if (got !== exp) begin
        miscompares = miscompares + 1;
        $display("CHECK FAILED %0t %s got %h exp %h", $time, msg, got, exp);
    end
endtask
task apb(input logic w, input logic [17:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
        @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
endtask
// ----------------------------------------
// Scenarios
// ----------------------------------------
task t_regs;
    apb(0, `TSW_ADDR_CTRL, 0);
    chk(rd, 32'h0, "ctrl reset");
    apb(0, `TSW_ADDR_ALIGN, 0);
    chk(rd & 32'h3000, 32'h0, "align reset");
    apb(0, 18'h30000, 0);
    chk({rd[30:0], er}, 32'h1, "unmapped read");
    apb(1, `TSW_ADDR_ALIGN, 1);
    chk({31'h0, er}, 32'h1, "align write");
    apb(1, 18'h20000, 1);
    chk({31'h0, er}, 32'h1, "data store write");
    apb(1, 18'h00094, 3);
    apb(0, 18'h00094, 0);
    chk(rd, 32'h3, "offset rw");
    apb(1, 18'h00094, 0);
    $display("regs test done");
endtask
task t_eval;
    integer t0;
    apb(1, `TSW_ADDR_CTRL, 32'h2);
    repeat (2 * FRAME) @(posedge pclk);
    apb(1, `TSW_ADDR_CTRL, 32'h12);
    t0 = cyc_n;
    rd = 0;
    while (rd[12] !== 1'b1 && cyc_n - t0 < 4 * FRAME)
        apb(0, `TSW_ADDR_ALIGN, 0);
    chk(rd & 32'h3fff, 32'h1000 | MEAS, "measure");
    chk({31'h0, cyc_n - t0 >= FRAME && cyc_n - t0 <= 2 * FRAME + 16}, 1, "done time");
    apb(1, `TSW_ADDR_CTRL, 32'h2);
    apb(0, `TSW_ADDR_ALIGN, 0);
    chk({31'h0, rd[12]}, 0, "done clear");
    $display("eval test done");
endtask
task t_block;
    integer i, t0;
    reg [2:0] b;
    for (i = 0; i < 2; i = i + 1) begin
        b = (i == 0) ? 3'h6 : 3'h0;
        apb(1, `TSW_ADDR_CTRL, {20'h0, 2'h2, b, 3'h4, 4'h2});
        t0 = cyc_n;
        rd = 32'h40;
        while (rd[6] !== 1'b0 && cyc_n - t0 < 3 * FRAME)
            apb(0, `TSW_ADDR_CTRL, 0);
        chk({31'h0, cyc_n - t0 <= 2 * FRAME + 16}, 1, "block time");
        apb(0, ad(18'h10000, 0, 0), 0);
        chk(rd, {16'h0, b, 13'h0}, "first word");
        apb(0, ad(18'h10000, 31, 255), 0);
        chk(rd, {16'h0, b, 13'h0}, "last word");
        if (i == 0) begin
            drive_enable_pin <= 1'b1;
            repeat (FRAME) @(posedge pclk);
            chk(tx_oe, 32'h0, "mode hiz");
            drive_enable_pin <= 1'b0;
        end
    end
    $display("block test done");
endtask
task t_switch;
    integer b;
    reg [7:0] v;
    apb(1, `TSW_ADDR_CTRL, 32'h2);
    drive_enable_pin <= 1'b1;
    apb(1, ad(18'h10000, 1, 9), 32'ha05a);
    apb(1, ad(18'h10000, 2, 20), 32'h6328);
    apb(1, ad(18'h10000, 4, 50), 32'h200a);
    apb(1, ad(18'h10000, 6, 60), 32'h200a);
    repeat (4 * FRAME) @(posedge pclk);
    apb(0, ad(18'h20000, 1, 9), 0);
    chk(rd, 32'h5a, "processor byte");
    apb(0, ad(18'h20000, 2, 20), 0);
    chk(rd, {24'h0, pat(3, 40)}, "const path");
    apb(0, ad(18'h20000, 4, 50), 0);
    chk(rd, {24'h0, pat(0, 10)}, "var path");
    apb(0, ad(18'h20000, 6, 60), 0);
    chk(rd, {24'h0, pat(0, 10)}, "shared source");
    apb(0, ad(18'h20000, 5, 7), 0);
    chk(rd, {24'h0, pat(5, 7)}, "serial in");
    apb(0, ad(18'h20000, 1, 10), 0);
    chk(rd, {24'h0, pat(1, 10)}, "no loop");
    // Stream 1 channel 9 on the pin, each bit taken half a clock into its two-clock cell
    @(negedge frame_sync_in);
    repeat (16 * 9 + 4) @(posedge pclk);
    for (b = 0; b < 8; b = b + 1) begin
        @(negedge pclk);
        v = {v[6:0], tx_out[1]};
        repeat (2) @(posedge pclk);
    end
    chk({24'h0, v}, 32'h5a, "processor pin");
    chk({31'h0, tx_oe != 32'h0}, 1, "driving");
    $display("switch test done");
endtask
task end_of_test;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
        $display("ALL TESTS PASSED");
    else
        $display("TESTS FAILED");
    $finish;
endtask
always @(posedge pclk) begin
    cyc_n = cyc_n + 1;
    if (cyc_n == 60000) begin
        miscompares = miscompares + 1;
        end_of_test;
    end
end
initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 18'h0;
    pwdata = 32'h0;
    drive_enable_pin = 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    repeat (20) @(posedge pclk);
    t_regs;
    t_eval;
    t_block;
    t_switch;
    end_of_test;
end
endmodule // tdm_timeslot_switch_core_bench
